/* File: design/stcs_regs.vh */
// register indices, field positions, reset values and timing constants
`ifndef STCS_REGS_VH
`define STCS_REGS_VH

// register indices within the block
`define STCS_IDX_SMOOTH      4'h0
`define STCS_IDX_RESEED      4'h1
`define STCS_IDX_IDLE        4'h2
`define STCS_IDX_MODE        4'h3
`define STCS_IDX_LPSLEEP     4'h4
`define STCS_IDX_CYCSLEEP    4'h5
`define STCS_IDX_RXCNT       4'h6
`define STCS_IDX_TXCNT       4'h7
`define STCS_IDX_XYRX        4'h8
`define STCS_IDX_XYTX        4'h9
`define STCS_IDX_PROXSET     4'hA
`define STCS_IDX_DRVHI       4'hB
`define STCS_IDX_DRVLO       4'hC
`define STCS_IDX_TDAMP       4'hD
`define STCS_IDX_HDAMP       4'hE
`define STCS_IDX_PDAMP       4'hF

// field positions
`define STCS_SM_TOUCH_OFF    0
`define STCS_SM_HOVER_OFF    1
`define STCS_SM_STATIC       2
`define STCS_PS_SELF         7
`define STCS_PS_BANK_B       6
`define STCS_PS_SUM_XY       4

// reset values
`define STCS_RST_SMOOTH      8'h00
`define STCS_RST_RESEED      8'h50
`define STCS_RST_IDLE        8'h64
`define STCS_RST_MODE        8'h08
`define STCS_RST_LPSLEEP     8'h08
`define STCS_RST_CYCSLEEP    8'h03
`define STCS_RST_RXCNT       8'h0A
`define STCS_RST_TXCNT       8'h0F
`define STCS_RST_PROXSET     8'h40
`define STCS_RST_DRVHI       8'h7F
`define STCS_RST_DRVLO       8'hFF
`define STCS_RST_TDAMP       8'h80
`define STCS_RST_HDAMP       8'h26
`define STCS_RST_PDAMP       8'h10

// timing: clock rate, interval step, derived cycle counts
`define STCS_CLK_HZ          20000000
`define STCS_STEP_MS         500
`define STCS_MS_CYC          (`STCS_CLK_HZ / 1000)
`define STCS_STEP_CYC        (`STCS_STEP_MS * `STCS_MS_CYC)

`endif

/* File: design/stcs_top.v */
// sense timing and channel setup register block
//
// What this block does
// - bit 2 picks static or dynamic touch filter
// - hover smoothing off bit skips hover filtering
// - touch smoothing off bit skips touch filtering
// - stuck normal-mode detection reseeds all but proximity
// - expiry in long-range mode reseeds proximity only
// - reseed interval counts 500 ms steps
// - host reseed command accepted any time
// - bus idle limit closes window, resumes sensing
// - ready line drops after bus idle limit
// - mode interval counts 500 ms steps
// - low-power mode sleeps per low-power code
// - normal mode always adds per-cycle sleep
// - sleep codes decode to fixed intervals
// - packet sizes follow line count registers
// - bit 7 picks self or mutual charging
// - bit 6 picks receiver group B
// - sum bit sums all xy receivers
// - pick field selects receive line 0-9
// - drive mask maps lines 14..0
// - self charging ignores drive mask
// - damping applied as value over 256
`timescale 1ns/1ns
`default_nettype none
`include "stcs_regs.vh"

module stcs_top #(
  parameter integer STEP_CYC = `STCS_STEP_CYC,
  parameter integer MS_CYC   = `STCS_MS_CYC
) (
  input  wire        clk_i,
  input  wire        resetn_i,
  // register port from the bus front end
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  input  wire [3:0]  reg_idx_i,
  input  wire [7:0]  reg_wdata_i,
  output reg  [7:0]  reg_rdata_o,
  input  wire        bus_ok_i,
  input  wire        host_reseed_i,
  // sensing engine side
  input  wire        window_open_i,
  input  wire        detect_i,
  input  wire        long_range_mode_i,
  input  wire        low_power_mode_i,
  input  wire        cycle_done_i,
  input  wire        mode_restart_i,
  output wire        touch_smoothing_off_o,
  output wire        hover_smoothing_off_o,
  output wire        touch_static_o,
  output reg  [8:0]  touch_damp_o,
  output reg  [8:0]  hover_damp_o,
  output reg  [8:0]  prox_damp_o,
  output reg         reseed_channels_o,
  output reg         reseed_prox_o,
  output reg         window_close_o,
  output reg         ready_o,
  output reg         mode_expired_o,
  output reg         sleep_busy_o,
  output reg         sleep_done_o,
  output reg  [15:0] packet_len_o,
  output wire        prox_self_o,
  output wire        prox_bank_b_o,
  output wire        prox_sum_xy_o,
  output reg  [9:0]  prox_rx_mask_o,
  output reg  [14:0] prox_tx_mask_o
);

  // ------------------------------------------------------------
  // reset synchroniser
  // ------------------------------------------------------------
  reg rst_meta_r;
  reg rst_n_r;

  // release is synchronous, assertion is immediate
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  reg [7:0] smooth_r;
  reg [7:0] reseed_int_r;
  reg [7:0] idle_lim_r;
  reg [7:0] mode_int_r;
  reg [7:0] lp_code_r;
  reg [7:0] cyc_code_r;
  reg [7:0] rx_cnt_r;
  reg [7:0] tx_cnt_r;
  reg [7:0] xy_rx_r;
  reg [7:0] xy_tx_r;
  reg [7:0] prox_set_r;
  reg [7:0] drv_hi_r;
  reg [7:0] drv_lo_r;
  reg [7:0] tdamp_r;
  reg [7:0] hdamp_r;
  reg [7:0] pdamp_r;

  // writes land one cycle after the strobe
  always @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      smooth_r     <= `STCS_RST_SMOOTH;
      reseed_int_r <= `STCS_RST_RESEED;
      idle_lim_r   <= `STCS_RST_IDLE;
      mode_int_r   <= `STCS_RST_MODE;
      lp_code_r    <= `STCS_RST_LPSLEEP;
      cyc_code_r   <= `STCS_RST_CYCSLEEP;
      rx_cnt_r     <= `STCS_RST_RXCNT;
      tx_cnt_r     <= `STCS_RST_TXCNT;
      xy_rx_r      <= `STCS_RST_RXCNT;
      xy_tx_r      <= `STCS_RST_TXCNT;
      prox_set_r   <= `STCS_RST_PROXSET;
      drv_hi_r     <= `STCS_RST_DRVHI;
      drv_lo_r     <= `STCS_RST_DRVLO;
      tdamp_r      <= `STCS_RST_TDAMP;
      hdamp_r      <= `STCS_RST_HDAMP;
      pdamp_r      <= `STCS_RST_PDAMP;
    end else if (reg_wr_i) begin
      case (reg_idx_i)
        `STCS_IDX_SMOOTH:   smooth_r     <= {5'h00, reg_wdata_i[2:0]};
        `STCS_IDX_RESEED:   reseed_int_r <= reg_wdata_i;
        `STCS_IDX_IDLE:     idle_lim_r   <= reg_wdata_i;
        `STCS_IDX_MODE:     mode_int_r   <= reg_wdata_i;
        `STCS_IDX_LPSLEEP:  lp_code_r    <= reg_wdata_i;
        `STCS_IDX_CYCSLEEP: cyc_code_r   <= reg_wdata_i;
        `STCS_IDX_RXCNT:    rx_cnt_r     <= reg_wdata_i;
        `STCS_IDX_TXCNT:    tx_cnt_r     <= reg_wdata_i;
        `STCS_IDX_XYRX:     xy_rx_r      <= reg_wdata_i;
        `STCS_IDX_XYTX:     xy_tx_r      <= reg_wdata_i;
        `STCS_IDX_PROXSET:  prox_set_r   <= {reg_wdata_i[7:6], 1'b0,
                                             reg_wdata_i[4:0]};
        `STCS_IDX_DRVHI:    drv_hi_r     <= {1'b0, reg_wdata_i[6:0]};
        `STCS_IDX_DRVLO:    drv_lo_r     <= reg_wdata_i;
        `STCS_IDX_TDAMP:    tdamp_r      <= reg_wdata_i;
        `STCS_IDX_HDAMP:    hdamp_r      <= reg_wdata_i;
        `STCS_IDX_PDAMP:    pdamp_r      <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // registered read data; unused bits were cleared on write
  always @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_idx_i)
        `STCS_IDX_SMOOTH:   reg_rdata_o <= smooth_r;
        `STCS_IDX_RESEED:   reg_rdata_o <= reseed_int_r;
        `STCS_IDX_IDLE:     reg_rdata_o <= idle_lim_r;
        `STCS_IDX_MODE:     reg_rdata_o <= mode_int_r;
        `STCS_IDX_LPSLEEP:  reg_rdata_o <= lp_code_r;
        `STCS_IDX_CYCSLEEP: reg_rdata_o <= cyc_code_r;
        `STCS_IDX_RXCNT:    reg_rdata_o <= rx_cnt_r;
        `STCS_IDX_TXCNT:    reg_rdata_o <= tx_cnt_r;
        `STCS_IDX_XYRX:     reg_rdata_o <= xy_rx_r;
        `STCS_IDX_XYTX:     reg_rdata_o <= xy_tx_r;
        `STCS_IDX_PROXSET:  reg_rdata_o <= prox_set_r;
        `STCS_IDX_DRVHI:    reg_rdata_o <= drv_hi_r;
        `STCS_IDX_DRVLO:    reg_rdata_o <= drv_lo_r;
        `STCS_IDX_TDAMP:    reg_rdata_o <= tdamp_r;
        `STCS_IDX_HDAMP:    reg_rdata_o <= hdamp_r;
        default:            reg_rdata_o <= pdamp_r;
      endcase
    end
  end

  // ------------------------------------------------------------
  // smoothing controls
  // ------------------------------------------------------------
  // filter type select and smoothing off bits
  assign touch_static_o        = smooth_r[`STCS_SM_STATIC];
  assign hover_smoothing_off_o = smooth_r[`STCS_SM_HOVER_OFF];
  assign touch_smoothing_off_o = smooth_r[`STCS_SM_TOUCH_OFF];

  // damping as value/256, fraction in 1.8 form
  always @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      touch_damp_o <= 9'h000;
      hover_damp_o <= 9'h000;
      prox_damp_o  <= 9'h000;
    end else begin
      touch_damp_o <= {1'b0, tdamp_r};
      hover_damp_o <= {1'b0, hdamp_r};
      prox_damp_o  <= {1'b0, pdamp_r};
    end
  end

  // ------------------------------------------------------------
  // millisecond and half-second tick dividers
  // ------------------------------------------------------------
  reg [31:0] ms_cnt_r;
  reg        ms_tick_r;
  reg [31:0] step_cnt_r;
  reg        step_tick_r;

  // free-running enables, one cycle wide
  always @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ms_cnt_r    <= 32'h0000_0000;
      ms_tick_r   <= 1'b0;
      step_cnt_r  <= 32'h0000_0000;
      step_tick_r <= 1'b0;
    end else begin
      ms_tick_r   <= (ms_cnt_r == MS_CYC - 1);
      ms_cnt_r    <= (ms_cnt_r == MS_CYC - 1) ? 32'h0000_0000
                                              : ms_cnt_r + 32'h1;
      step_tick_r <= (step_cnt_r == STEP_CYC - 1);
      step_cnt_r  <= (step_cnt_r == STEP_CYC - 1) ? 32'h0000_0000
                                                  : step_cnt_r + 32'h1;
    end
  end

  // ------------------------------------------------------------
  // stuck detection reseed
  // ------------------------------------------------------------
  reg [7:0] stuck_cnt_r;

  // a zero interval disables the automatic reseed
  always @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      stuck_cnt_r       <= 8'h00;
      reseed_channels_o <= 1'b0;
      reseed_prox_o     <= 1'b0;
    end else begin
      reseed_channels_o <= 1'b0;
      reseed_prox_o     <= 1'b0;
      if (!detect_i) begin
        stuck_cnt_r <= 8'h00;
      end else if (step_tick_r && reseed_int_r != 8'h00) begin
        if (stuck_cnt_r + 8'h01 >= reseed_int_r) begin
          stuck_cnt_r <= 8'h00;
          if (long_range_mode_i)
            reseed_prox_o <= 1'b1;
          else
            reseed_channels_o <= 1'b1;
        end else begin
          stuck_cnt_r <= stuck_cnt_r + 8'h01;
        end
      end
      // host command reseeds regardless of timer
      if (host_reseed_i) begin
        stuck_cnt_r       <= 8'h00;
        reseed_channels_o <= 1'b1;
        reseed_prox_o     <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // bus idle window timeout
  // ------------------------------------------------------------
  reg [7:0] idle_cnt_r;

  // ready follows the window, dropped early on timeout
  always @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      idle_cnt_r     <= 8'h00;
      window_close_o <= 1'b0;
      ready_o        <= 1'b0;
    end else begin
      window_close_o <= 1'b0;
      if (!window_open_i) begin
        idle_cnt_r <= 8'h00;
        ready_o    <= 1'b0;
      end else if (bus_ok_i) begin
        idle_cnt_r <= 8'h00;
        ready_o    <= 1'b1;
      // a closing pulse keeps ready low for the next cycle only
      end else if (!window_close_o &&
                   (ready_o || idle_cnt_r == 8'h00)) begin
        ready_o <= 1'b1;
        // close window after idle limit in ms
        if (ms_tick_r) begin
          if (idle_cnt_r + 8'h01 >= idle_lim_r) begin
            window_close_o <= 1'b1;
            ready_o        <= 1'b0;
            idle_cnt_r     <= 8'h00;
          end else begin
            idle_cnt_r <= idle_cnt_r + 8'h01;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // mode switch interval
  // ------------------------------------------------------------
  reg [7:0] mode_cnt_r;

  // expiry pulse after interval in half-second steps
  always @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_cnt_r     <= 8'h00;
      mode_expired_o <= 1'b0;
    end else begin
      mode_expired_o <= 1'b0;
      if (mode_restart_i) begin
        mode_cnt_r <= 8'h00;
      end else if (step_tick_r) begin
        if (mode_cnt_r + 8'h01 >= mode_int_r) begin
          mode_cnt_r     <= 8'h00;
          mode_expired_o <= 1'b1;
        end else begin
          mode_cnt_r <= mode_cnt_r + 8'h01;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // sleep timer
  // ------------------------------------------------------------
  // code to milliseconds; 0 or out of range is no sleep
  function [12:0] sleep_ms;
    input [7:0] code;
    begin
      case (code)
        8'h01:   sleep_ms = 13'd1;
        8'h02:   sleep_ms = 13'd2;
        8'h03:   sleep_ms = 13'd5;
        8'h04:   sleep_ms = 13'd10;
        8'h05:   sleep_ms = 13'd20;
        8'h06:   sleep_ms = 13'd40;
        8'h07:   sleep_ms = 13'd80;
        8'h08:   sleep_ms = 13'd160;
        8'h09:   sleep_ms = 13'd320;
        8'h0A:   sleep_ms = 13'd640;
        8'h0B:   sleep_ms = 13'd1200;
        8'h0C:   sleep_ms = 13'd2400;
        8'h0D:   sleep_ms = 13'd5000;
        default: sleep_ms = 13'd0;
      endcase
    end
  endfunction

  reg  [13:0] sleep_cnt_r;
  wire [13:0] sleep_len;

  // per-cycle sleep always, plus low-power sleep
  // low-power sleep when that mode is active
  assign sleep_len = {1'b0, sleep_ms(cyc_code_r)} +
                     (low_power_mode_i ? {1'b0, sleep_ms(lp_code_r)}
                                       : 14'h0000);

  // sleep starts at end of each acquisition cycle unless a sleep is already running
  always @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sleep_cnt_r  <= 14'h0000;
      sleep_busy_o <= 1'b0;
      sleep_done_o <= 1'b0;
    end else begin
      sleep_done_o <= 1'b0;
      if (cycle_done_i && !sleep_busy_o) begin
        if (sleep_len == 14'h0000) begin
          sleep_done_o <= 1'b1;
        end else begin
          sleep_cnt_r  <= sleep_len;
          sleep_busy_o <= 1'b1;
        end
      end else if (sleep_busy_o && ms_tick_r) begin
        if (sleep_cnt_r == 14'h0001) begin
          sleep_busy_o <= 1'b0;
          sleep_done_o <= 1'b1;
        end
        sleep_cnt_r <= sleep_cnt_r - 14'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // channel setup outputs
  // ------------------------------------------------------------
  // packet length: one word per channel plus xy
  always @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      packet_len_o <= 16'h0000;
    end else begin
      packet_len_o <= rx_cnt_r * tx_cnt_r + xy_rx_r * xy_tx_r;
    end
  end

  assign prox_self_o   = prox_set_r[`STCS_PS_SELF];
  assign prox_bank_b_o = prox_set_r[`STCS_PS_BANK_B];
  assign prox_sum_xy_o = prox_set_r[`STCS_PS_SUM_XY];

  // receive and drive selection of the long-range channel
  always @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      prox_rx_mask_o <= 10'h000;
      prox_tx_mask_o <= 15'h0000;
    end else begin
      // all xy receive lines when summing
      if (prox_set_r[`STCS_PS_SUM_XY])
        prox_rx_mask_o <= (xy_rx_r >= 8'd10) ? 10'h3FF :
                          (10'h001 << xy_rx_r[3:0]) - 10'h001;
      // single picked line, 10-15 select none
      else if (prox_set_r[3:0] <= 4'h9)
        prox_rx_mask_o <= 10'h001 << prox_set_r[3:0];
      else
        prox_rx_mask_o <= 10'h000;
      if (prox_set_r[`STCS_PS_SELF])
        prox_tx_mask_o <= 15'h0000;
      else
        prox_tx_mask_o <= {drv_hi_r[6:0], drv_lo_r};
    end
  end

endmodule

`default_nettype wire

/* File: tb/stcs_checker_properties.sv */
// checker: timing relations on the top ports of the setup block
`timescale 1ns/1ns
`default_nettype none
module stcs_checker (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        reg_wr_i,
  input wire logic [3:0]  reg_idx_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        host_reseed_i,
  input wire logic        window_open_i,
  input wire logic        bus_ok_i,
  input wire logic        detect_i,
  input wire logic        long_range_mode_i,
  input wire logic        touch_smoothing_off_o,
  input wire logic        hover_smoothing_off_o,
  input wire logic        touch_static_o,
  input wire logic [8:0]  touch_damp_o,
  input wire logic        reseed_channels_o,
  input wire logic        reseed_prox_o,
  input wire logic        window_close_o,
  input wire logic        ready_o,
  input wire logic        mode_expired_o,
  input wire logic        prox_self_o,
  input wire logic        prox_bank_b_o,
  input wire logic        prox_sum_xy_o,
  input wire logic [14:0] prox_tx_mask_o
);
  // ----------------------------------------
  // one clock domain, reset pin silences all
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  AST_SMOOTH: assert property (
    reg_wr_i && reg_idx_i == 4'h0 |=> {touch_static_o,
    hover_smoothing_off_o, touch_smoothing_off_o} == $past(reg_wdata_i[2:0]))
    else $error("smoothing bits differ from written byte");
  AST_PROX_BITS: assert property (
    reg_wr_i && reg_idx_i == 4'hA |=> {prox_self_o, prox_bank_b_o} ==
    $past(reg_wdata_i[7:6]) && prox_sum_xy_o == $past(reg_wdata_i[4]))
    else $error("proximity setup bits differ from written byte");
  AST_SELF_TX: assert property (
    $past(prox_self_o) |-> prox_tx_mask_o == 15'h0)
    else $error("drive mask live under self charging");
  AST_DAMP: assert property (
    reg_wr_i && reg_idx_i == 4'hD |=> ##1
    touch_damp_o == {1'b0, $past(reg_wdata_i, 2)})
    else $error("touch damping differs from written byte");
  AST_HOST_RESEED: assert property (
    host_reseed_i |=> reseed_channels_o && reseed_prox_o)
    else $error("host reseed not obeyed");
  AST_AUTO_RESEED: assert property (
    reseed_channels_o && !$past(host_reseed_i) |->
    $past(detect_i) && !$past(long_range_mode_i))
    else $error("channel reseed without stuck detection");
  AST_PROX_RESEED: assert property (
    reseed_prox_o && !$past(host_reseed_i) |->
    $past(detect_i) && $past(long_range_mode_i))
    else $error("proximity reseed outside long range mode");
  AST_READY: assert property (
    $rose(window_open_i) |=> ready_o)
    else $error("ready not raised for open window");
  AST_CLOSE: assert property (
    window_close_o |-> ##[0:1] !ready_o)
    else $error("ready still high after timeout");
  AST_CLOSE_HOLD: assert property (
    window_close_o |=> !ready_o)
    else $error("ready raised again after timeout");
  AST_BUS_OK: assert property (
    bus_ok_i |=> !window_close_o [*3])
    else $error("window closed right after bus activity");
  AST_MODE: assert property (
    mode_expired_o |=> !mode_expired_o [*8])
    else $error("mode interval far too short");
endmodule
`default_nettype wire

/* File: tb/stcs_sense_model.sv */
// sensing engine model: opens the window, drops it on timeout
`timescale 1ns/1ns
`default_nettype none
module stcs_sense_model (
  input  wire logic clk_i,
  input  wire logic open_req_i,
  input  wire logic close_i,
  output var  logic window_open_o
);
  initial window_open_o = 1'b0;
  // late update keeps the change off the sampling edge
  always @(posedge clk_i) begin
    if (close_i)
      window_open_o <= #1 1'b0;
    else if (open_req_i)
      window_open_o <= #1 1'b1;
  end
endmodule
`default_nettype wire

/* File: tb/test_sense_timing_channel_setup.sv */
// testbench for the sense timing and channel setup block
`timescale 1ns/1ns
`default_nettype none
module test_sense_timing_channel_setup;
  logic clk_i = 0, resetn_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [3:0] reg_idx_i = 0;
  logic [7:0] reg_wdata_i = 0;
  logic detect_i = 0, long_range_mode_i = 0, low_power_mode_i = 0;
  logic [4:0] pl = 0;
  wire window_open_i, ts, hs, st, rc, rp, wc, rdy, me, sb, sd, ps, pb, px;
  wire [7:0] reg_rdata_o;
  wire [8:0] td, hd, pd;
  wire [15:0] plen;
  wire [9:0] rxm;
  wire [14:0] txm;
  wire [4:0] ev = {sd, me, wc, rp, rc};
  int failures = 0, cmp_count = 0, cyc = 0, n;
  logic [7:0] rstv [16] = '{8'h00, 8'h50, 8'h64, 8'h08, 8'h08, 8'h03,
    8'h0A, 8'h0F, 8'h0A, 8'h0F, 8'h40, 8'h7F, 8'hFF, 8'h80, 8'h26, 8'h10};
  int ms [5] = '{1, 2, 5, 10, 20};

  always #25 clk_i = ~clk_i;

  stcs_top #(.STEP_CYC(20), .MS_CYC(4)) dut (.clk_i(clk_i),
    .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_idx_i(reg_idx_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .bus_ok_i(pl[0]), .host_reseed_i(pl[1]),
    .window_open_i(window_open_i), .detect_i(detect_i),
    .long_range_mode_i(long_range_mode_i),
    .low_power_mode_i(low_power_mode_i), .cycle_done_i(pl[2]),
    .mode_restart_i(pl[3]), .touch_smoothing_off_o(ts),
    .hover_smoothing_off_o(hs), .touch_static_o(st), .touch_damp_o(td),
    .hover_damp_o(hd), .prox_damp_o(pd), .reseed_channels_o(rc),
    .reseed_prox_o(rp), .window_close_o(wc), .ready_o(rdy),
    .mode_expired_o(me), .sleep_busy_o(sb), .sleep_done_o(sd),
    .packet_len_o(plen), .prox_self_o(ps), .prox_bank_b_o(pb),
    .prox_sum_xy_o(px), .prox_rx_mask_o(rxm), .prox_tx_mask_o(txm));
  stcs_sense_model far (.clk_i(clk_i), .open_req_i(pl[4]),
    .close_i(wc), .window_open_o(window_open_i));

  // ----------------------------------------
  // access and check tasks
  // ----------------------------------------
  task automatic tick(input int c = 1);
    repeat (c) @(posedge clk_i) #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %0s expected %h seen %h", nm, e, g);
    end
  endtask
  // extra edge at the end lets registered outputs settle
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    tick();
    reg_wr_i = 1;
    reg_idx_i = i;
    reg_wdata_i = d;
    tick();
    reg_wr_i = 0;
    tick();
  endtask
  task automatic rd(input logic [3:0] i, input logic [7:0] e);
    tick();
    reg_rd_i = 1;
    reg_idx_i = i;
    tick();
    reg_rd_i = 0;
    tick();
    chk("read", {8'h00, e}, {8'h00, reg_rdata_o});
  endtask
  // one-cycle pulse on a side input
  task automatic pls(input int b);
    pl[b] = 1;
    tick();
    pl = 0;
  endtask
  // waits for an output pulse, bounded, counting edges
  task automatic wait_ev(input int s, input int lim);
    n = 0;
    do begin
      tick();
      n++;
    end while (ev[s] !== 1'b1 && n < lim);
  endtask
  task automatic rng(input string nm, input int lo, hi);
    chk(nm, 16'h1, {15'h0, n >= lo && n <= hi});
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard, far above the roughly one thousand cycles needed
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    tick(12);
    resetn_i = 1;
    tick(3);
    for (int k = 0; k < 16; k++)
      rd(k[3:0], rstv[k]);
    chk("packet", 16'h012C, plen);
    chk("txmask", 16'h7FFF, {1'b0, txm});
    chk("rxmask", 16'h0001, {6'h0, rxm});
    chk("damp", 16'h0080, {7'h0, td});
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      wr(4'h0, 8'h01 << k);
      chk("smooth", 16'h1 << k, {13'h0, st, hs, ts});
    end
    wr(4'h0, 8'hFF);
    rd(4'h0, 8'h07);
    wr(4'hA, 8'hFF);
    rd(4'hA, 8'hDF);
    wr(4'hB, 8'hFF);
    rd(4'hB, 8'h7F);
    $display("test fields done");
    wr(4'hB, 8'h12);
    wr(4'hC, 8'h34);
    for (int k = 0; k < 10; k++) begin
      wr(4'hA, k[7:0]);
      chk("rxpick", 16'h1 << k, {6'h0, rxm});
    end
    chk("txmask", 16'h1234, {1'b0, txm});
    wr(4'hA, 8'hD3);
    chk("prox", 16'h0007, {13'h0, ps, pb, px});
    chk("selftx", 16'h0000, {1'b0, txm});
    wr(4'hA, 8'h0A);
    chk("rxnone", 16'h0000, {6'h0, rxm});
    $display("test prox done");
    wr(4'h6, 8'h03);
    wr(4'h7, 8'h04);
    wr(4'h8, 8'h02);
    wr(4'h9, 8'h05);
    chk("packet", 16'd22, plen);
    wr(4'hD, 8'h01);
    wr(4'hE, 8'hFF);
    wr(4'hF, 8'h80);
    chk("damps", 16'h0001, {7'h0, td});
    chk("damph", 16'h00FF, {7'h0, hd});
    chk("dampp", 16'h0080, {7'h0, pd});
    pls(1);
    chk("hostrs", 16'h0003, {14'h0, rc, rp});
    $display("test setup done");
    wr(4'h1, 8'h03);
    detect_i = 1;
    wait_ev(0, 100);
    rng("stuck", 40, 62);
    chk("noprox", 16'h0000, {15'h0, rp});
    detect_i = 0;
    for (int k = 0; k < 6; k++) begin
      tick();
      detect_i = 1;
      wait_ev(0, 35);
      chk("restart", 16'd35, n[15:0]);
      detect_i = 0;
    end
    tick();
    long_range_mode_i = 1;
    detect_i = 1;
    wait_ev(1, 100);
    rng("lrstuck", 40, 62);
    chk("lronly", 16'h0000, {15'h0, rc});
    detect_i = 0;
    long_range_mode_i = 0;
    $display("test reseed done");
    wr(4'h2, 8'h05);
    pls(4);
    tick(2);
    chk("ready", 16'h0001, {15'h0, rdy});
    repeat (3) begin
      pls(0);
      wait_ev(2, 12);
      chk("busok", 16'd12, n[15:0]);
    end
    wait_ev(2, 40);
    rng("idle", 4, 10);
    tick(3);
    chk("rdylow", 16'h0000, {15'h0, rdy});
    $display("test window done");
    wr(4'h3, 8'h02);
    pls(3);
    wait_ev(3, 100);
    rng("mode1", 20, 42);
    wait_ev(3, 100);
    chk("mode2", 16'd40, n[15:0]);
    for (int k = 0; k < 5; k++) begin
      wr(4'h5, k[7:0] + 8'h01);
      pls(2);
      chk("busy", 16'h0001, {15'h0, sb});
      wait_ev(4, 200);
      rng("sleep", (ms[k] - 1) * 4, ms[k] * 4 + 2);
    end
    low_power_mode_i = 1;
    wr(4'h5, 8'h01);
    wr(4'h4, 8'h04);
    pls(2);
    wait_ev(4, 200);
    rng("lpsleep", 36, 46);
    $display("test sleep done");
    stop_test();
  end
endmodule

bind stcs_top stcs_checker u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
  .reg_wr_i(reg_wr_i), .reg_idx_i(reg_idx_i), .reg_wdata_i(reg_wdata_i),
  .host_reseed_i(host_reseed_i), .window_open_i(window_open_i),
  .bus_ok_i(bus_ok_i), .detect_i(detect_i),
  .long_range_mode_i(long_range_mode_i),
  .touch_smoothing_off_o(touch_smoothing_off_o),
  .hover_smoothing_off_o(hover_smoothing_off_o),
  .touch_static_o(touch_static_o), .touch_damp_o(touch_damp_o),
  .reseed_channels_o(reseed_channels_o), .reseed_prox_o(reseed_prox_o),
  .window_close_o(window_close_o), .ready_o(ready_o),
  .mode_expired_o(mode_expired_o), .prox_self_o(prox_self_o),
  .prox_bank_b_o(prox_bank_b_o), .prox_sum_xy_o(prox_sum_xy_o),
  .prox_tx_mask_o(prox_tx_mask_o));
`default_nettype wire
